// ---- mwpwm_channels.sv ----
// Multi-width PWM channels of the programmable counter array
// Operation
// - 8-bit mode: output goes high when counter low byte equals compare low.
// - 8-bit mode: output goes low when counter low byte overflows.
// - 8-bit mode: on rollover FF to 00 compare low reloads from high.
// - Enable, PWM select and length select 00b give 8-bit mode.
// - Match flag enabled: event flag set on a match that raises the output (pin was low).
// - Overflow flag set at each overflow, every 256 counts in 8-bit.
// - Writing compare low clears enable; writing compare high sets it.
// - 8-bit high fraction is (256 - high byte)/256; zero gives 100%.
// - Channel with enable cleared holds its output low.
// - All PWM channels share one common cycle length.
// - Channels outside PWM mode stay free for other counter modes.
// - Reload access select routes reads and writes to reload or compare.
// - N-bit mode: output high when low N counter bits equal compare.
// - Carry out of bit N: output low, overflow flag, compare reloads.
// - Enable, PWM select and non-8-bit length give 9/10/11-bit mode.
// - Overflow every 512/1024/2048 counts; match flags as in 8-bit.
// - N-bit high fraction is (2^N - compare)/2^N.
`default_nettype none

module mwpwm_channels
    import mwpwm_pkg::*;
#(
    parameter int NUM_CH = MWPWM_NUM_CH_DEF
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_count_tick,
    input wire mwpwm_cycle_length_select_t i_cycle_length_select,
    input wire logic i_reload_access_select,
    input wire mwpwm_ch_cfg_t [NUM_CH-1:0] i_ch_cfg,
    input wire mwpwm_wr_t i_wr,
    input wire mwpwm_rd_t i_rd,
    input wire mwpwm_mode_wr_t i_mode_wr,
    input wire logic i_cycle_overflow_flag_clr,
    input wire logic [NUM_CH-1:0] i_channel_event_flag_clr,
    output logic [NUM_CH-1:0] o_channel_output_pin,
    output logic [NUM_CH-1:0] o_pwm_active,
    output logic [NUM_CH-1:0] o_compare_enable_bit,
    output logic [NUM_CH-1:0] o_channel_event_flag,
    output logic o_cycle_overflow_flag,
    output logic [MWPWM_CNT_W-1:0] o_counter,
    output logic [7:0] o_rd_data
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [MWPWM_CNT_W-1:0] cnt_r;
    logic [7:0] cmp_lo_r [NUM_CH];
    logic [7:0] cmp_hi_r [NUM_CH];
    logic [7:0] arl_lo_r [NUM_CH];
    logic [7:0] arl_hi_r [NUM_CH];
    logic [NUM_CH-1:0] cmp_en_r;
    logic [NUM_CH-1:0] pin_r;
    logic [NUM_CH-1:0] evt_r;
    logic ovf_flag_r;
    logic [7:0] rd_data_r;

    logic [10:0] mask;
    logic is8;
    logic ovf;
    logic [MWPWM_CNT_W-1:0] cnt_nxt;
    logic [10:0] cnt_low_nxt;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0] match;
    logic [10:0] cmp_eff [NUM_CH];

    // ------------------------------------------------------------------
    // Shared counter and cycle length
    // ------------------------------------------------------------------
    // One length select for every channel, so lengths cannot be mixed
    assign mask = mwpwm_len_mask(i_cycle_length_select);
    assign is8 = (i_cycle_length_select == MWPWM_CL_8);
    assign cnt_nxt = cnt_r + MWPWM_CNT_STEP;
    assign cnt_low_nxt = cnt_nxt[10:0] & mask;
    // Carry out of bit N is the step from all-ones to zero
    assign ovf = i_count_tick && ((cnt_r[10:0] & mask) == mask);

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r <= MWPWM_CNT_RST;
        end else if (i_count_tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel compare path
    // ------------------------------------------------------------------
    // Compare against the value the reload brings in on the same step,
    // so a zero high byte matches at count zero and stays high
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            active[c] = cmp_en_r[c] & i_ch_cfg[c].pwm_sel;
            if (is8) begin
                cmp_eff[c] = {3'h0, (ovf ? cmp_hi_r[c] : cmp_lo_r[c])};
            end else if (ovf) begin
                cmp_eff[c] = {arl_hi_r[c][2:0], arl_lo_r[c]} & mask;
            end else begin
                cmp_eff[c] = {cmp_hi_r[c][2:0], cmp_lo_r[c]} & mask;
            end
            match[c] = i_count_tick && active[c]
                && (cnt_low_nxt == cmp_eff[c]);
        end
    end

    // Non-PWM channels leave the pin low here; other mode logic owns it
    assign o_pwm_active = active;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!active[c]) begin
                    pin_r[c] <= 1'b0;
                end else if (match[c]) begin
                    pin_r[c] <= 1'b1;
                end else if (ovf) begin
                    pin_r[c] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare and reload registers
    // ------------------------------------------------------------------
    // A software write in the reload cycle wins for the byte it writes
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                cmp_lo_r[c] <= MWPWM_BYTE_RST;
                cmp_hi_r[c] <= MWPWM_BYTE_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (ovf && active[c]) begin
                    if (is8) begin
                        cmp_lo_r[c] <= cmp_hi_r[c];
                    end else begin
                        cmp_lo_r[c] <= arl_lo_r[c];
                        cmp_hi_r[c] <= arl_hi_r[c];
                    end
                end
                if (i_wr.en && !i_reload_access_select
                    && i_wr.ch == MWPWM_CH_IDX_W'(c)) begin
                    if (i_wr.hi) begin
                        cmp_hi_r[c] <= i_wr.data;
                    end else begin
                        cmp_lo_r[c] <= i_wr.data;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                arl_lo_r[c] <= MWPWM_BYTE_RST;
                arl_hi_r[c] <= MWPWM_BYTE_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (i_wr.en && i_reload_access_select
                    && i_wr.ch == MWPWM_CH_IDX_W'(c)) begin
                    if (i_wr.hi) begin
                        arl_hi_r[c] <= i_wr.data;
                    end else begin
                        arl_lo_r[c] <= i_wr.data;
                    end
                end
            end
        end
    end

    // Byte writes steer enable last, after a direct mode write
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmp_en_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (i_mode_wr.en && i_mode_wr.ch == MWPWM_CH_IDX_W'(c)) begin
                    cmp_en_r[c] <= i_mode_wr.cmp_en;
                end
                if (i_wr.en && !i_reload_access_select
                    && i_wr.ch == MWPWM_CH_IDX_W'(c)) begin
                    cmp_en_r[c] <= i_wr.hi;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags, set wins over clear
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ovf_flag_r <= 1'b0;
        end else begin
            ovf_flag_r <= (ovf_flag_r & ~i_cycle_overflow_flag_clr)
                | ovf;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            evt_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                evt_r[c] <= (evt_r[c] & ~i_channel_event_flag_clr[c])
                    | (match[c] & ~pin_r[c]
                       & i_ch_cfg[c].match_flag_en);
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rd_data_r <= MWPWM_BYTE_RST;
        end else begin
            rd_data_r <= MWPWM_BYTE_RST;
            for (int c = 0; c < NUM_CH; c++) begin
                if (i_rd.ch == MWPWM_CH_IDX_W'(c)) begin
                    if (i_reload_access_select) begin
                        rd_data_r <= i_rd.hi ? arl_hi_r[c] : arl_lo_r[c];
                    end else begin
                        rd_data_r <= i_rd.hi ? cmp_hi_r[c] : cmp_lo_r[c];
                    end
                end
            end
        end
    end

    assign o_channel_output_pin = pin_r;
    assign o_compare_enable_bit = cmp_en_r;
    assign o_channel_event_flag = evt_r;
    assign o_cycle_overflow_flag = ovf_flag_r;
    assign o_counter = cnt_r;
    assign o_rd_data = rd_data_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_ovf_flag_set: assert property (
        ovf |=> o_cycle_overflow_flag)
        else $error("overflow flag not set");

    a_ovf_at_wrap: assert property (
        $past(i_count_tick) && ((cnt_r[10:0] & mask) == MWPWM_ZERO_11)
        && $stable(i_cycle_length_select) |-> o_cycle_overflow_flag)
        else $error("wrap without overflow flag");

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        a_rise_on_match: assert property (
            $rose(pin_r[g]) && !$past(i_wr.en) && $past(is8)
            |-> cnt_r[7:0] == cmp_lo_r[g])
            else $error("output rose without match");

        a_fall_at_wrap: assert property (
            $fell(pin_r[g]) && $past(active[g])
            |-> (cnt_r[10:0] & $past(mask)) == MWPWM_ZERO_11)
            else $error("output fell away from overflow");

        a_reload_8bit: assert property (
            ovf && active[g] && is8 && !i_wr.en
            |=> cmp_lo_r[g] == $past(cmp_hi_r[g]))
            else $error("8-bit reload missed");

        a_reload_nbit: assert property (
            ovf && active[g] && !is8 && !i_wr.en
            |=> cmp_lo_r[g] == $past(arl_lo_r[g])
                && cmp_hi_r[g] == $past(arl_hi_r[g]))
            else $error("auto-reload missed");

        a_enable_by_write: assert property (
            i_wr.en && !i_reload_access_select && i_wr.ch == g
            |=> o_compare_enable_bit[g] == $past(i_wr.hi))
            else $error("write did not steer enable");

        a_disabled_low: assert property (
            !cmp_en_r[g] ##1 !cmp_en_r[g] |-> !pin_r[g])
            else $error("disabled channel output high");

        a_event_on_match: assert property (
            $rose(pin_r[g]) && $past(i_ch_cfg[g].match_flag_en)
            |-> o_channel_event_flag[g])
            else $error("match flag not set");

        a_reload_route: assert property (
            i_wr.en && i_reload_access_select && !ovf
            |=> $stable(cmp_lo_r[g]) && $stable(cmp_hi_r[g]))
            else $error("reload access touched compare");
    end

    c_rise: cover property ($rose(pin_r[0]));
    c_full_duty: cover property (
        is8 && active[0] && cmp_hi_r[0] == MWPWM_BYTE_RST
        && ovf ##1 pin_r[0]);
    c_ovf_nbit: cover property (ovf && !is8);
    c_clear_race: cover property (ovf && i_cycle_overflow_flag_clr);

endmodule : mwpwm_channels

`default_nettype wire

// ---- mwpwm_pkg.sv ----
// Shared constants and types of the multi-width PWM channel block
`default_nettype none

package mwpwm_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int MWPWM_CNT_W = 16;
    localparam int MWPWM_CH_IDX_W = 3;
    localparam int MWPWM_NUM_CH_DEF = 3;
    localparam logic [7:0] MWPWM_BYTE_RST = 8'h00;
    localparam logic [MWPWM_CNT_W-1:0] MWPWM_CNT_RST = 16'h0000;
    localparam logic [MWPWM_CNT_W-1:0] MWPWM_CNT_STEP = 16'h0001;
    localparam logic [10:0] MWPWM_ZERO_11 = 11'h000;

    // ------------------------------------------------------------------
    // Cycle length masks
    // ------------------------------------------------------------------
    localparam logic [10:0] MWPWM_MASK_8 = 11'h0ff;
    localparam logic [10:0] MWPWM_MASK_9 = 11'h1ff;
    localparam logic [10:0] MWPWM_MASK_10 = 11'h3ff;
    localparam logic [10:0] MWPWM_MASK_11 = 11'h7ff;

    typedef enum logic [1:0] {
        MWPWM_CL_8 = 2'b00,
        MWPWM_CL_9 = 2'b01,
        MWPWM_CL_10 = 2'b10,
        MWPWM_CL_11 = 2'b11
    } mwpwm_cycle_length_select_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pwm_sel;
        logic match_flag_en;
    } mwpwm_ch_cfg_t;

    typedef struct packed {
        logic en;
        logic [MWPWM_CH_IDX_W-1:0] ch;
        logic hi;
        logic [7:0] data;
    } mwpwm_wr_t;

    typedef struct packed {
        logic [MWPWM_CH_IDX_W-1:0] ch;
        logic hi;
    } mwpwm_rd_t;

    typedef struct packed {
        logic en;
        logic [MWPWM_CH_IDX_W-1:0] ch;
        logic cmp_en;
    } mwpwm_mode_wr_t;

    function automatic logic [10:0] mwpwm_len_mask(input mwpwm_cycle_length_select_t sel);
        logic [10:0] m;
        m = MWPWM_MASK_8;
        unique case (sel)
            MWPWM_CL_8: m = MWPWM_MASK_8;
            MWPWM_CL_9: m = MWPWM_MASK_9;
            MWPWM_CL_10: m = MWPWM_MASK_10;
            MWPWM_CL_11: m = MWPWM_MASK_11;
        endcase
        return m;
    endfunction : mwpwm_len_mask

endpackage : mwpwm_pkg

`default_nettype wire

// ---- mwpwm_channels_tb.sv ----
// Self-checking testbench of the multi-width PWM channel block
`default_nettype none

module mwpwm_channels_tb
    import mwpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    mwpwm_cycle_length_select_t cycle_length_select = MWPWM_CL_8;
    logic reload_access_select = 1'b0;
    mwpwm_ch_cfg_t [2:0] cfg = '0;
    mwpwm_wr_t wr = '0;
    mwpwm_rd_t rd = '0;
    mwpwm_mode_wr_t mwr = '0;
    logic ovf_clr = 1'b0;
    logic [2:0] ev_clr = 3'h0;
    logic [2:0] pin;
    logic [2:0] act;
    logic [2:0] cen;
    logic [2:0] ev;
    logic ovf;
    logic [MWPWM_CNT_W-1:0] cnt;
    logic [7:0] rdd;
    logic [7:0] d;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    mwpwm_channels #(.NUM_CH(3)) mwpwm_channels_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_count_tick(tick),
        .i_cycle_length_select(cycle_length_select), .i_reload_access_select(reload_access_select),
        .i_ch_cfg(cfg), .i_wr(wr), .i_rd(rd), .i_mode_wr(mwr),
        .i_cycle_overflow_flag_clr(ovf_clr),
        .i_channel_event_flag_clr(ev_clr),
        .o_channel_output_pin(pin), .o_pwm_active(act),
        .o_compare_enable_bit(cen), .o_channel_event_flag(ev),
        .o_cycle_overflow_flag(ovf), .o_counter(cnt), .o_rd_data(rdd)
    );

    // ------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------
    task automatic results();
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Longest run is about 12300 cycles; the 40000 limit is over three times that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            results();
        end
    end

    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk8

    task automatic chk_n(input string n, input int e, input int g);
        total_checks++;
        if (g != e) begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_n

    // ------------------------------------------------------------------
    // Drivers, all entered and left at a falling edge
    // ------------------------------------------------------------------
    task automatic wr_byte(input logic [2:0] ch, input logic hi,
                           input logic [7:0] v);
        wr = '{en: 1'b1, ch: ch, hi: hi, data: v};
        @(negedge clk);
        wr.en = 1'b0;
        // Idle edge so a following write never re-raises en at once
        @(negedge clk);
    endtask : wr_byte

    task automatic rd_byte(input logic [2:0] ch, input logic hi);
        rd = '{ch: ch, hi: hi};
        @(negedge clk);
        d = rdd;
    endtask : rd_byte

    // Clears the flags, waits a fresh wrap, then counts one whole period
    task automatic measure(input int n, input int e0, input int e1,
                           input int e2);
        int hc [3] = '{0, 0, 0};
        int per = 0;
        int k = 0;
        ovf_clr = 1'b1;
        @(negedge clk);
        ovf_clr = 1'b0;
        while (ovf !== 1'b1 && k < 4096) begin
            @(negedge clk);
            k++;
        end
        ovf_clr = 1'b1;
        ev_clr = 3'h7;
        do begin
            @(negedge clk);
            // Drop the clears once, so flags set in the measured period are held
            if (per == 0) begin
                ovf_clr = 1'b0;
                ev_clr = 3'h0;
            end
            per++;
            for (int c = 0; c < 3; c++) hc[c] += (pin[c] === 1'b1);
        end while (ovf !== 1'b1 && per < 4096);
        chk_n("period", 1 << n, per);
        chk8("cnt_wrap", 8'h00, cnt[7:0]);
        chk_n("high0", e0, hc[0]);
        chk_n("high1", e1, hc[1]);
        chk_n("high2", e2, hc[2]);
        chk1("event0", e0 > 0 && e0 < (1 << n), ev[0]);
        chk1("event1", 1'b0, ev[1]);
    endtask : measure

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_setup();
        chk1("rst_pin", 1'b0, pin[0] | pin[1] | pin[2]);
        chk1("rst_flag", 1'b0, ovf | ev[0]);
        chk8("cnt_idle", 8'h00, cnt[7:0]);
        cfg = '{'{1'b0, 1'b1}, '{1'b1, 1'b0}, '{1'b1, 1'b1}};
        wr_byte(3'h0, 1'b0, 8'h40);
        chk1("cen_lo", 1'b0, cen[0]);
        wr_byte(3'h0, 1'b1, 8'hc0);
        chk1("cen_hi", 1'b1, cen[0]);
        chk1("active0", 1'b1, act[0]);
        wr_byte(3'h1, 1'b0, 8'h00);
        wr_byte(3'h1, 1'b1, 8'h80);
        wr_byte(3'h2, 1'b1, 8'h10);
        chk1("active2", 1'b0, act[2]);
        wr_byte(3'h7, 1'b1, 8'h55);
        rd_byte(3'h7, 1'b1);
        chk8("rd_range", 8'h00, d);
    endtask : t_setup

    task automatic t_pwm8();
        tick = 1'b1;
        measure(8, 64, 128, 0);
        rd_byte(3'h0, 1'b0);
        chk8("reload_lo", 8'hc0, d);
        wr_byte(3'h0, 1'b1, 8'h00);
        measure(8, 256, 128, 0);
    endtask : t_pwm8

    task automatic t_nbit();
        reload_access_select = 1'b1;
        wr_byte(3'h0, 1'b0, 8'h00);
        wr_byte(3'h0, 1'b1, 8'h01);
        chk1("cen_reload_access_select", 1'b1, cen[0]);
        rd_byte(3'h0, 1'b1);
        chk8("ar_hi", 8'h01, d);
        for (int s = 1; s < 4; s++) begin
            cycle_length_select = mwpwm_cycle_length_select_t'(s);
            measure(8 + s, (1 << (8 + s)) - 256, 1 << (8 + s), 0);
        end
        reload_access_select = 1'b0;
        rd_byte(3'h0, 1'b1);
        chk8("cmp_hi", 8'h01, d);
        rd_byte(3'h0, 1'b0);
        chk8("cmp_lo", 8'h00, d);
    endtask : t_nbit

    task automatic t_disable();
        mwr = '{en: 1'b1, ch: 3'h0, cmp_en: 1'b0};
        @(negedge clk);
        mwr.en = 1'b0;
        chk1("cen_off", 1'b0, cen[0]);
        chk1("active_off", 1'b0, act[0]);
        measure(11, 0, 2048, 0);
    endtask : t_disable

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_setup();
        t_pwm8();
        t_nbit();
        t_disable();
        results();
    end

endmodule : mwpwm_channels_tb

`default_nettype wire
